//--- core/fahc_regs.svh
// Timing constants, widths and counter values for the flash converter host port
`ifndef FAHC_REGS_SVH
`define FAHC_REGS_SVH
`define FAHC_CLK_PERIOD_NS  10
`define FAHC_CONV_R_MAX_NS  2500
`define FAHC_TD_WR_NS       400
`define FAHC_TW_W_NS        500
`define FAHC_TD_INT_MAX_NS  1300
`define FAHC_TD_RIH_MAX_NS  225
`define FAHC_TA_INT_MAX_NS  50
`define FAHC_TDIS_MAX_NS    95
`define FAHC_TD_RDY_MAX_NS  100
`define FAHC_TD_RIL_MAX_NS  290
`define FAHC_TA_R2_MAX_NS   150
`define FAHC_SYNC_CYC       3
`define FAHC_CYC_UP(ns)     (((ns) + `FAHC_CLK_PERIOD_NS - 1) / `FAHC_CLK_PERIOD_NS)
`define FAHC_CNT_W          12
`define FAHC_DATA_W         8
`define FAHC_FIFO_DEPTH     8
`define FAHC_ONE            12'h001
`define FAHC_ZERO           12'h000
`endif

//--- core/fahc_pkg.sv
// Types shared by the flash converter host port
`default_nettype none
package fahc_pkg;
   typedef enum logic [3:0] {
      FAHC_IDLE, FAHC_R_CS, FAHC_R_WAIT, FAHC_R_DATA, FAHC_W_LOW, FAHC_W_WAIT,
      FAHC_W_RD, FAHC_W_DATA, FAHC_REL, FAHC_GAP
   } fahc_state_type;
endpackage : fahc_pkg
`default_nettype wire

//--- core/fahc_stream_if.sv
// Valid/ready stream carrier between host port and its FIFO
`default_nettype none
interface fahc_stream_if #(parameter int WIDTH = 9);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : fahc_stream_if
`default_nettype wire

//--- core/fahc_fifo.sv
// Small synchronous FIFO with registered read data
`default_nettype none
module fahc_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic    core_clk_in,
   input  wire logic    resetn_in,
   fahc_stream_if.snk   wr,
   output logic         out_valid_out,
   input  wire logic    out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wp_reg;
   logic [AW-1:0]    rp_reg;
   logic [AW:0]      cnt_reg;
   logic             push;
   logic             load;
   // Room counts the output register too, so DEPTH words in total
   assign wr.ready = ((cnt_reg + (AW+1)'(out_valid_out)) != DEPTH[AW:0]);
   assign push = wr.valid && wr.ready;
   assign load = (cnt_reg != '0) && (!out_valid_out || out_ready_in);
   always_ff @(posedge core_clk_in) begin
      if (push) begin
         mem_reg[wp_reg] <= wr.data;
      end
   end
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= wp_reg + 1'b1;
         end
         if (load) begin
            rp_reg <= rp_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(load);
      end
   end
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         out_valid_out <= 1'b0;
         out_data_out  <= '0;
      end else if (load) begin
         out_valid_out <= 1'b1;
         out_data_out  <= mem_reg[rp_reg];
      end else if (out_ready_in) begin
         out_valid_out <= 1'b0;
      end
   end
endmodule : fahc_fifo
`default_nettype wire

//--- core/fahc_host.sv
// Host controller driving the flash converter parallel port
`default_nettype none
`include "fahc_regs.svh"
module fahc_host
   import fahc_pkg::*;
(
   input  wire logic                   core_clk_in,
   input  wire logic                   resetn_in,
   input  wire logic                   start_in,
   input  wire logic                   mode_wr_in,
   input  wire logic                   early_read_in,
   output logic                        busy_out,
   output logic                        timeout_out,
   output logic                        res_valid_out,
   input  wire logic                   res_ready_in,
   output logic [`FAHC_DATA_W:0]       res_data_out,
   output logic                        cs_n_out,
   output logic                        rd_n_out,
   output logic                        mode_out,
   output logic                        wr_rdy_n_out,
   output logic                        wr_rdy_oe_out,
   input  wire logic                   wr_rdy_n_in,
   input  wire logic                   int_n_in,
   input  wire logic [`FAHC_DATA_W-1:0] result_data_bus_in,
   input  wire logic                   over_range_flag_n_in
);
   localparam logic [`FAHC_CNT_W-1:0] CONV_R  = `FAHC_CNT_W'(`FAHC_CYC_UP(`FAHC_CONV_R_MAX_NS + `FAHC_TA_INT_MAX_NS));
   localparam logic [`FAHC_CNT_W-1:0] TD_WR   = `FAHC_CNT_W'(`FAHC_CYC_UP(`FAHC_TD_WR_NS));
   localparam logic [`FAHC_CNT_W-1:0] TW_W    = `FAHC_CNT_W'(`FAHC_CYC_UP(`FAHC_TW_W_NS));
   localparam logic [`FAHC_CNT_W-1:0] TD_INT  = `FAHC_CNT_W'(`FAHC_CYC_UP(`FAHC_TD_INT_MAX_NS + `FAHC_TA_INT_MAX_NS));
   localparam logic [`FAHC_CNT_W-1:0] TD_RIH  = `FAHC_CNT_W'(`FAHC_CYC_UP(`FAHC_TD_RIH_MAX_NS + `FAHC_TDIS_MAX_NS));
   localparam logic [`FAHC_CNT_W-1:0] TD_RDY  = `FAHC_CNT_W'(`FAHC_CYC_UP(`FAHC_TD_RDY_MAX_NS));
   localparam logic [`FAHC_CNT_W-1:0] TD_EARLY = `FAHC_CNT_W'(`FAHC_CYC_UP(`FAHC_TD_RIL_MAX_NS + `FAHC_TA_INT_MAX_NS));
   localparam logic [`FAHC_CNT_W-1:0] TD_ACC   = `FAHC_CNT_W'(`FAHC_CYC_UP(`FAHC_TA_R2_MAX_NS) + `FAHC_SYNC_CYC);

   fahc_state_type                 state_reg;
   logic [`FAHC_CNT_W-1:0]         cnt_reg;
   logic                           wmode_reg;
   logic                           early_reg;
   logic [1:0]                     int_sync_reg;
   logic [1:0]                     rdy_sync_reg;
   logic [1:0]                     ovf_sync_reg;
   logic [`FAHC_DATA_W-1:0]        d_s1_reg;
   logic [`FAHC_DATA_W-1:0]        d_s2_reg;
   logic                           push_reg;
   logic [`FAHC_DATA_W:0]          word_reg;
   logic                           int_low;
   logic                           rdy_low;

   fahc_stream_if #(.WIDTH(`FAHC_DATA_W+1)) st ();

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         int_sync_reg <= 2'h3;
         rdy_sync_reg <= 2'h3;
         ovf_sync_reg <= 2'h3;
         d_s1_reg     <= 8'h00;
         d_s2_reg     <= 8'h00;
      end else begin
         int_sync_reg <= {int_sync_reg[0], int_n_in};
         rdy_sync_reg <= {rdy_sync_reg[0], wr_rdy_n_in};
         ovf_sync_reg <= {ovf_sync_reg[0], over_range_flag_n_in};
         d_s1_reg     <= result_data_bus_in;
         d_s2_reg     <= d_s1_reg;
      end
   end
   assign int_low = !int_sync_reg[1];
   assign rdy_low = !rdy_sync_reg[1];

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg   <= FAHC_IDLE;
         cnt_reg     <= `FAHC_ZERO;
         wmode_reg   <= 1'b0;
         early_reg   <= 1'b0;
         timeout_out <= 1'b0;
      end else begin
         cnt_reg <= cnt_reg + `FAHC_ONE;
         case (state_reg)
            FAHC_IDLE: begin
               cnt_reg <= `FAHC_ZERO;
               if (start_in && st.ready && !int_low) begin
                  wmode_reg   <= mode_wr_in;
                  early_reg   <= early_read_in;
                  timeout_out <= 1'b0;
                  state_reg   <= mode_wr_in ? FAHC_W_LOW : FAHC_R_CS;
               end
            end
            FAHC_R_CS: begin
               if (cnt_reg >= TD_RDY) begin
                  cnt_reg   <= `FAHC_ZERO;
                  state_reg <= FAHC_R_WAIT;
               end
            end
            FAHC_R_WAIT: begin
               if (int_low && !rdy_low) begin
                  state_reg <= FAHC_R_DATA;
               end else if (cnt_reg >= CONV_R) begin
                  timeout_out <= 1'b1;
                  state_reg   <= FAHC_R_DATA;
               end
            end
            FAHC_R_DATA: begin
               cnt_reg   <= `FAHC_ZERO;
               state_reg <= FAHC_REL;
            end
            FAHC_W_LOW: begin
               if (cnt_reg >= TW_W) begin
                  cnt_reg   <= `FAHC_ZERO;
                  state_reg <= FAHC_W_WAIT;
               end
            end
            FAHC_W_WAIT: begin
               if (early_reg && cnt_reg >= TD_WR) begin
                  cnt_reg   <= `FAHC_ZERO;
                  state_reg <= FAHC_W_RD;
               end else if (!early_reg && int_low) begin
                  cnt_reg   <= `FAHC_ZERO;
                  state_reg <= FAHC_W_RD;
               end else if (cnt_reg >= TD_INT) begin
                  timeout_out <= 1'b1;
                  cnt_reg     <= `FAHC_ZERO;
                  state_reg   <= FAHC_W_RD;
               end
            end
            FAHC_W_RD: begin
               if (int_low && cnt_reg >= TD_ACC) begin
                  state_reg <= FAHC_W_DATA;
               end else if (cnt_reg >= TD_EARLY) begin
                  timeout_out <= 1'b1;
                  state_reg   <= FAHC_W_DATA;
               end
            end
            FAHC_W_DATA: begin
               cnt_reg   <= `FAHC_ZERO;
               state_reg <= FAHC_REL;
            end
            FAHC_REL: begin
               if (cnt_reg >= TD_RIH) begin
                  cnt_reg   <= `FAHC_ZERO;
                  state_reg <= FAHC_GAP;
               end
            end
            FAHC_GAP: begin
               if (!int_low) begin
                  state_reg <= FAHC_IDLE;
               end
            end
            default: begin
               state_reg <= FAHC_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cs_n_out      <= 1'b1;
         rd_n_out      <= 1'b1;
         wr_rdy_n_out  <= 1'b1;
         wr_rdy_oe_out <= 1'b0;
         mode_out      <= 1'b0;
      end else begin
         mode_out      <= (state_reg == FAHC_IDLE) ? mode_wr_in : wmode_reg;
         wr_rdy_oe_out <= (state_reg == FAHC_IDLE) ? mode_wr_in : wmode_reg;
         wr_rdy_n_out  <= !(state_reg == FAHC_W_LOW);
         cs_n_out      <= !(state_reg inside {FAHC_R_CS, FAHC_R_WAIT, FAHC_R_DATA, FAHC_W_LOW,
                                              FAHC_W_WAIT, FAHC_W_RD, FAHC_W_DATA});
         rd_n_out      <= !(state_reg inside {FAHC_R_WAIT, FAHC_R_DATA, FAHC_W_RD, FAHC_W_DATA}
                            || (state_reg == FAHC_R_CS && cnt_reg >= TD_RDY));
      end
   end

   // ----------------------------------------
   // Result capture
   // ----------------------------------------
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         push_reg <= 1'b0;
         word_reg <= 9'h000;
      end else begin
         if (state_reg == FAHC_R_DATA || state_reg == FAHC_W_DATA) begin
            push_reg <= 1'b1;
            word_reg <= {!ovf_sync_reg[1], d_s2_reg};
         end else if (st.ready) begin
            push_reg <= 1'b0;
         end
      end
   end
   assign st.valid = push_reg;
   assign st.data  = word_reg;
   assign busy_out = (state_reg != FAHC_IDLE);

   fahc_fifo #(.WIDTH(`FAHC_DATA_W+1), .DEPTH(`FAHC_FIFO_DEPTH)) u_fifo (
      .core_clk_in   (core_clk_in),
      .resetn_in     (resetn_in),
      .wr            (st),
      .out_valid_out (res_valid_out),
      .out_ready_in  (res_ready_in),
      .out_data_out  (res_data_out)
   );
endmodule : fahc_host
`default_nettype wire

//--- tb/fahc_host_props.sv
// Assertion checker for the flash converter host port
`default_nettype none
module fahc_host_props (
   input wire logic       core_clk_in,
   input wire logic       resetn_in,
   input wire logic       res_valid_out,
   input wire logic       res_ready_in,
   input wire logic [8:0] res_data_out,
   input wire logic       cs_n_out,
   input wire logic       rd_n_out,
   input wire logic       mode_out,
   input wire logic       wr_rdy_n_out,
   input wire logic       wr_rdy_oe_out,
   input wire logic       int_n_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [11:0] low_cnt_reg;
   logic [11:0] high_cnt_reg;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!resetn_in);
   // ------------------------------
   // Write strobe timing counters
   // ------------------------------
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         low_cnt_reg <= 12'h000;
         high_cnt_reg <= 12'hFFF;
      end else if (wr_rdy_oe_out && !wr_rdy_n_out) begin
         low_cnt_reg <= low_cnt_reg + 12'h001;
         high_cnt_reg <= 12'h000;
      end else begin
         low_cnt_reg <= 12'h000;
         high_cnt_reg <= (high_cnt_reg == 12'hFFF) ? high_cnt_reg : high_cnt_reg + 12'h001;
      end
   end
   property p_rd_sel; !rd_n_out |-> !cs_n_out; endproperty
   a_rd_sel: assert property (p_rd_sel) else $error("read strobe without chip select");
   property p_oe_mode; !cs_n_out |-> wr_rdy_oe_out == mode_out; endproperty
   a_oe_mode: assert property (p_oe_mode) else $error("shared pin direction wrong for mode");
   property p_wr_sel; wr_rdy_oe_out && !wr_rdy_n_out |-> !cs_n_out; endproperty
   a_wr_sel: assert property (p_wr_sel) else $error("write strobe without chip select");
   property p_wr_width; $rose(wr_rdy_n_out) && wr_rdy_oe_out |-> low_cnt_reg >= 12'h032; endproperty
   a_wr_width: assert property (p_wr_width) else $error("write strobe too short");
   property p_early_gap; $fell(rd_n_out) && mode_out |-> high_cnt_reg >= 12'h028; endproperty
   a_early_gap: assert property (p_early_gap) else $error("read too soon after write");
   property p_mode_hold; !cs_n_out && !$past(cs_n_out) |-> $stable(mode_out); endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed while selected");
   property p_next_start; $fell(cs_n_out) |-> int_n_in; endproperty
   a_next_start: assert property (p_next_start) else $error("new select while interrupt low");
   property p_rd_release; $rose(rd_n_out) |-> !int_n_in; endproperty
   a_rd_release: assert property (p_rd_release) else $error("read raised before completion");
   property p_res_hold; res_valid_out && !res_ready_in |=> res_valid_out && $stable(res_data_out); endproperty
   a_res_hold: assert property (p_res_hold) else $error("result word not held");
   c_read: cover property ($fell(rd_n_out) && !mode_out);
   c_early: cover property ($fell(rd_n_out) && mode_out && int_n_in);
   c_pop: cover property (res_valid_out && res_ready_in);
endmodule : fahc_host_props
bind fahc_host fahc_host_props i_props (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
   .res_valid_out(res_valid_out), .res_ready_in(res_ready_in), .res_data_out(res_data_out),
   .cs_n_out(cs_n_out), .rd_n_out(rd_n_out), .mode_out(mode_out), .wr_rdy_n_out(wr_rdy_n_out),
   .wr_rdy_oe_out(wr_rdy_oe_out), .int_n_in(int_n_in));
`default_nettype wire

//--- tb/fahc_conv_model.sv
// Behavioural model of the flash converter pins
`default_nettype none
module fahc_conv_model #(
   parameter int CONV_CYC = 160,
   parameter int INT_CYC  = 80,
   parameter int RIL_CYC  = 25
) (
   input  wire logic       clk_in,
   input  wire logic       cs_n_in,
   input  wire logic       rd_n_in,
   input  wire logic       mode_in,
   input  wire logic       wr_pin_in,
   input  wire logic [7:0] value_in,
   input  wire logic       over_in,
   output logic            int_n_out = 1'b1,
   output logic            rdy_low_out = 1'b0,
   output logic [7:0]      data_out,
   output logic            over_n_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       cs_q = 1'b1;
   logic       rd_q = 1'b1;
   logic       wr_q = 1'b1;
   logic       conv = 1'b0;
   logic       ovf = 1'b0;
   logic [7:0] res = 8'h00;
   int         cnt = 0;
   always @(posedge clk_in) begin
      cs_q <= cs_n_in;
      rd_q <= rd_n_in;
      wr_q <= wr_pin_in;
      if (conv && cnt > 1) cnt <= cnt - 1;
      if (!mode_in && !cs_n_in && cs_q) rdy_low_out <= 1'b1;
      if (!mode_in && !cs_n_in && !rd_n_in && rd_q) begin
         conv <= 1'b1;
         cnt <= CONV_CYC;
      end
      if (mode_in && !cs_n_in && wr_pin_in && !wr_q) begin
         conv <= 1'b1;
         cnt <= INT_CYC;
         if (!rd_n_in) int_n_out <= 1'b1;
      end
      if (conv && mode_in && !cs_n_in && !rd_n_in && rd_q && cnt > RIL_CYC) cnt <= RIL_CYC;
      if (conv && cnt == 1) begin
         conv <= 1'b0;
         int_n_out <= 1'b0;
         rdy_low_out <= 1'b0;
         res <= value_in;
         ovf <= over_in;
      end
      if ((rd_n_in && !rd_q) || (cs_n_in && !cs_q)) int_n_out <= 1'b1;
   end
   assign data_out = (!cs_n_in && !rd_n_in && !int_n_out) ? res : ~res;
   assign over_n_out = !ovf;
endmodule : fahc_conv_model
`default_nettype wire

//--- tb/fahc_host_tb_top.sv
// Self-checking testbench for the flash converter host port
`default_nettype none
module fahc_host_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rstn, start, mode_wr, early, ready, busy, tmo, valid;
   logic cs_n, rd_n, mode, wr_n, oe, int_n, rdy_low, ovf_n, over, wr_pin;
   logic [8:0] data;
   logic [7:0] bus, value;
   int fails, comparisons;
   assign wr_pin = oe ? wr_n : !rdy_low;
   fahc_host i_dut (.core_clk_in(clk), .resetn_in(rstn), .start_in(start), .mode_wr_in(mode_wr),
      .early_read_in(early), .busy_out(busy), .timeout_out(tmo), .res_valid_out(valid),
      .res_ready_in(ready), .res_data_out(data), .cs_n_out(cs_n), .rd_n_out(rd_n), .mode_out(mode),
      .wr_rdy_n_out(wr_n), .wr_rdy_oe_out(oe), .wr_rdy_n_in(wr_pin), .int_n_in(int_n),
      .result_data_bus_in(bus), .over_range_flag_n_in(ovf_n));
   fahc_conv_model i_model (.clk_in(clk), .cs_n_in(cs_n), .rd_n_in(rd_n), .mode_in(mode),
      .wr_pin_in(wr_pin), .value_in(value), .over_in(over), .int_n_out(int_n),
      .rdy_low_out(rdy_low), .data_out(bus), .over_n_out(ovf_n));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic report_and_stop;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   task automatic check(string name, logic [8:0] exp, logic [8:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic wait_busy(logic lvl);
      int n;
      n = 0;
      while (busy !== lvl) begin
         @(negedge clk);
         n++;
         if (n > 3000) begin
            fails++;
            $display("CHECK FAILED busy expected %b seen %b", lvl, busy);
            report_and_stop();
         end
      end
   endtask : wait_busy
   task automatic convert(logic m, logic e, logic [7:0] v, logic o);
      @(negedge clk);
      value = v;
      over = o;
      mode_wr = m;
      early = e;
      start = 1'b1;
      wait_busy(1'b1);
      start = 1'b0;
      wait_busy(1'b0);
      check("timeout", 9'h000, {8'h00, tmo});
   endtask : convert
   task automatic pop(logic [8:0] exp);
      int n;
      n = 0;
      while (valid !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      if (valid !== 1'b1) begin
         fails++;
         $display("CHECK FAILED valid expected 1 seen %b", valid);
         report_and_stop();
      end
      check("result", exp, data);
      ready = 1'b1;
      @(negedge clk);
      ready = 1'b0;
   endtask : pop
   task automatic t_read;
      convert(1'b0, 1'b0, 8'hA5, 1'b0);
      pop(9'h0A5);
   endtask : t_read
   task automatic t_write;
      convert(1'b1, 1'b0, 8'h3C, 1'b0);
      pop(9'h03C);
   endtask : t_write
   task automatic t_early;
      convert(1'b1, 1'b1, 8'hC3, 1'b0);
      pop(9'h0C3);
   endtask : t_early
   task automatic t_over;
      convert(1'b0, 1'b0, 8'hFF, 1'b1);
      pop(9'h1FF);
      convert(1'b1, 1'b0, 8'h00, 1'b0);
      pop(9'h000);
   endtask : t_over
   task automatic t_fill;
      for (int i = 0; i < 8; i++) convert(i[0], 1'b0, 8'(i * 17), 1'b0);
      @(negedge clk);
      start = 1'b1;
      repeat (20) @(negedge clk);
      check("busy", 9'h000, {8'h00, busy});
      start = 1'b0;
      for (int i = 0; i < 8; i++) begin
         repeat (3) @(negedge clk);
         pop(9'(i * 17));
      end
   endtask : t_fill
   initial begin
      fails = 0;
      comparisons = 0;
      rstn = 1'b0;
      start = 1'b0;
      mode_wr = 1'b0;
      early = 1'b0;
      ready = 1'b0;
      value = 8'h00;
      over = 1'b0;
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      t_read();
      t_write();
      t_early();
      t_over();
      t_fill();
      report_and_stop();
   end
endmodule : fahc_host_tb_top
`default_nettype wire
